/* shared/clk_sel_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef CLK_SEL_MAP_SVH
`define CLK_SEL_MAP_SVH

// ==========================================================
// Register byte offsets
`define OFS_CLOCK_DIVISOR    12'h000
`define OFS_PLL_FEEDBACK     12'h004
`define OFS_FAST_RC_TUNE     12'h008
`define OFS_SOURCE_CFG       12'h00C
`define OFS_STATUS           12'h010
`define OFS_AUX_CFG          12'h014

// ==========================================================
// Clock divisor register fields, reset values and divider constants
`define CDIV_PRE_LSB         0
`define CDIV_PRE_MSB         4
`define CDIV_POST_LSB        6
`define CDIV_POST_MSB        7
`define CDIV_FRC_LSB         8
`define CDIV_FRC_MSB         10
`define CDIV_RESET           16'h0040
`define FBD_RESET            9'h030
`define FBD_OFFSET           10'h002
`define PRE_OFFSET           6'h02
`define TUNE_RESET           6'h00
`define FRC16_SHIFT          5'h04

// ==========================================================
// Frequencies in kHz, except SLOW_RC_HZ and SYS_CLK_HZ in Hz
`define FAST_RC_KHZ          7370
`define SLOW_RC_HZ           32768
`define SYS_CLK_HZ           40000000
`define SYS_CLK_KHZ          40000
`define INSTR_MAX_KHZ        40000
`define PLL_OUT_MIN_KHZ      12500
`define PLL_OUT_MAX_KHZ      80000
`define VCO_MIN_KHZ          100000
`define VCO_MAX_KHZ          200000

// Clock ticks per half period of the slow RC reference
`define SLOW_RC_HALF_CYC     ((`SYS_CLK_HZ / `SLOW_RC_HZ) / 2)

`endif

/* shared/clk_sel_pkg.sv */
// Types for the system clock select and PLL block
package clk_sel_pkg;

    typedef enum logic [2:0] {
        SRC_FAST_RC      = 3'b000,
        SRC_FAST_RC_PLL  = 3'b001,
        SRC_PRIMARY      = 3'b010,
        SRC_PRIMARY_PLL  = 3'b011,
        SRC_SECOND       = 3'b100,
        SRC_SLOW_RC      = 3'b101,
        SRC_FAST_RC_D16  = 3'b110,
        SRC_FAST_RC_DIVN = 3'b111
    } source_sel_e;

    typedef enum logic [1:0] {
        PRI_EXTERNAL     = 2'b00,
        PRI_CRYSTAL_LOW  = 2'b01,
        PRI_CRYSTAL_HIGH = 2'b10,
        PRI_OFF          = 2'b11
    } primary_mode_e;

    typedef struct packed {
        logic [2:0] initial_source_sel;
        logic [1:0] primary_mode_sel;
        logic       osc_pin_function_cfg;
    } cfg_word_s;

    typedef struct packed {
        logic [4:0] pll_prescale_sel;
        logic [1:0] pll_postscale_sel;
        logic [2:0] fast_rc_postscale_sel;
        logic [8:0] pll_feedback_sel;
    } pll_cfg_s;

    typedef struct packed {
        logic       pll_in_use;
        logic       cfg_invalid;
        logic [2:0] active_source;
        logic [1:0] active_primary;
    } clk_status_s;

endpackage

/* rtl/clk_sel_pll.sv */
// System clock source selection, PLL and clock dividers
//
// The address map and the AHB-Lite slave port were decided locally.
`include "clk_sel_map.svh"
`timescale 1ns/10ps
`default_nettype none

module clk_sel_pll
    import clk_sel_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic [5:0]  source_select_cfg_word,
    input  wire logic        osc_in_pin,
    input  wire logic        second_crystal_in_pin,
    input  wire logic        aux_clk_in,
    input  wire logic        pll_ref_tick,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hsel,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             osc_out_pin_o,
    output logic             osc_out_pin_oe,
    output logic             instr_clk_en,
    output logic             sys_osc_tick,
    output logic             slow_rc_clk,
    output logic             auxiliary_clock_source,
    output logic      [2:0]  active_source,
    output logic      [31:0] fosc_ratio_num,
    output logic      [15:0] fosc_ratio_den
);

    // ==========================================================
    // Bus slave
    cfg_word_s   cfg_s;
    logic        wr_pend_ff;
    logic [11:0] wr_addr_ff;
    logic [15:0] clock_divisor_reg_ff;
    logic [8:0]  pll_feedback_reg_ff;
    logic [5:0]  tune_ff;
    logic        aux_sel_ff;
    logic [31:0] hrdata_ff;
    logic        bus_take;
    logic [31:0] nxt_rdata;

    assign cfg_s     = source_select_cfg_word;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    assign bus_take  = hsel && hready && htrans[1];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
        end
        else if (clk_en && hready)
        begin
            wr_pend_ff <= bus_take && hwrite;
            wr_addr_ff <= haddr[11:0];
        end
    end

    // Software-written divider and tuning state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            clock_divisor_reg_ff <= `CDIV_RESET;
            pll_feedback_reg_ff  <= `FBD_RESET;
            tune_ff              <= `TUNE_RESET;
            aux_sel_ff           <= 1'b0;
        end
        else if (clk_en && wr_pend_ff)
        begin
            case (wr_addr_ff)
                `OFS_CLOCK_DIVISOR: clock_divisor_reg_ff <= {5'h00,
                    hwdata[10:6], 1'b0, hwdata[4:0]};
                `OFS_PLL_FEEDBACK:  pll_feedback_reg_ff <= hwdata[8:0];
                `OFS_FAST_RC_TUNE:  tune_ff <= hwdata[5:0];
                `OFS_AUX_CFG:       aux_sel_ff <= hwdata[0];
                default:            aux_sel_ff <= aux_sel_ff;
            endcase
        end
    end

    // ==========================================================
    // Power-on source capture
    logic [2:0] src_ff;
    logic [1:0] pri_ff;
    logic       pin_fn_ff;
    logic       captured_ff;

    // Sampled at the first enabled edge after reset release
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            src_ff      <= SRC_FAST_RC;
            pri_ff      <= PRI_OFF;
            pin_fn_ff   <= 1'b0;
            captured_ff <= 1'b0;
        end
        else if (clk_en && !captured_ff)
        begin
            src_ff      <= cfg_s.initial_source_sel;
            pri_ff      <= cfg_s.primary_mode_sel;
            pin_fn_ff   <= cfg_s.osc_pin_function_cfg;
            captured_ff <= 1'b1;
        end
    end

    // ==========================================================
    // Decode of selected mode
    logic       use_pll;
    logic       use_primary;
    logic       post_bad;
    logic       pri_bad;
    logic       cfg_bad;
    logic [4:0] pre_f;
    logic [1:0] post_f;
    logic [2:0] fast_rc_postscale_sel_f;
    logic [3:0] post_div;
    logic [8:0] frc_div;

    assign pre_f    = clock_divisor_reg_ff[`CDIV_PRE_MSB:`CDIV_PRE_LSB];
    assign post_f   = clock_divisor_reg_ff[`CDIV_POST_MSB:`CDIV_POST_LSB];
    assign fast_rc_postscale_sel_f = clock_divisor_reg_ff[`CDIV_FRC_MSB:`CDIV_FRC_LSB];

    always_comb
    begin
        use_pll     = 1'b0;
        use_primary = 1'b0;
        case (source_sel_e'(src_ff))
            SRC_FAST_RC_PLL:  use_pll = 1'b1;
            SRC_PRIMARY:      use_primary = 1'b1;
            SRC_PRIMARY_PLL:
            begin
                use_primary = 1'b1;
                use_pll     = 1'b1;
            end
            default:          use_pll = 1'b0;
        endcase
    end

    always_comb
    begin
        case (post_f)
            2'b00:   post_div = 4'd2;
            2'b01:   post_div = 4'd4;
            2'b11:   post_div = 4'd8;
            default: post_div = 4'd4;
        endcase
    end
    assign post_bad = (post_f == 2'b10);
    assign pri_bad  = use_primary && (pri_ff == PRI_OFF);
    assign cfg_bad  = post_bad || pri_bad;

    always_comb
    begin
        case (fast_rc_postscale_sel_f)
            3'd7:    frc_div = 9'd256;
            default: frc_div = 9'(9'd1 << fast_rc_postscale_sel_f);
        endcase
    end

    // ==========================================================
    // Effective settings, held at last valid values while invalid
    pll_cfg_s eff_ff;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            eff_ff <= {5'h00, 2'b01, 3'b000, `FBD_RESET};
        end
        else if (clk_en && !cfg_bad)
        begin
            eff_ff <= {pre_f, post_f, fast_rc_postscale_sel_f, pll_feedback_reg_ff};
        end
    end

    // Frequency ratio of fosc to the source: num over den
    logic [9:0]  mult;
    logic [5:0]  pre_div;
    logic [3:0]  eff_post;
    logic [8:0]  eff_frc;

    assign mult    = {1'b0, eff_ff.pll_feedback_sel} + `FBD_OFFSET;
    assign pre_div = {1'b0, eff_ff.pll_prescale_sel} + `PRE_OFFSET;

    always_comb
    begin
        case (eff_ff.pll_postscale_sel)
            2'b00:   eff_post = 4'd2;
            2'b11:   eff_post = 4'd8;
            default: eff_post = 4'd4;
        endcase
        case (eff_ff.fast_rc_postscale_sel)
            3'd7:    eff_frc = 9'd256;
            default: eff_frc = 9'(9'd1 << eff_ff.fast_rc_postscale_sel);
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fosc_ratio_num <= 32'h0000_0001;
            fosc_ratio_den <= 16'h0001;
        end
        else if (clk_en)
        begin
            if (use_pll)
            begin
                fosc_ratio_num <= {22'h00_0000, mult};
                fosc_ratio_den <= 16'({pre_div, 4'h0} >> 4) * 16'(eff_post);
            end
            else if (src_ff == SRC_FAST_RC_DIVN)
            begin
                fosc_ratio_num <= 32'h0000_0001;
                fosc_ratio_den <= {7'h00, eff_frc};
            end
            else if (src_ff == SRC_FAST_RC_D16)
            begin
                fosc_ratio_num <= 32'h0000_0001;
                fosc_ratio_den <= 16'h0010;
            end
            else
            begin
                fosc_ratio_num <= 32'h0000_0001;
                fosc_ratio_den <= 16'h0001;
            end
        end
    end

    // ==========================================================
    // Oscillator tick selection and divide by two
    logic [8:0]  frc_cnt_ff;
    logic        frc_tick;
    logic        src_tick;
    logic        osc_in_q_ff;
    logic        second_q_ff;
    logic        slow_rc_ff;
    logic [9:0]  slow_cnt_ff;
    logic        half_ff;

    // Fast RC modeled by the core clock and postscaled; tune_ff is not applied
    always_ff @(posedge clk)
    begin
        if (rst)
            frc_cnt_ff <= 9'h000;
        else if (clk_en)
            frc_cnt_ff <= frc_tick ? 9'h000 : frc_cnt_ff + 9'h001;
    end
    assign frc_tick = (src_ff == SRC_FAST_RC_D16)
                    ? (frc_cnt_ff >= 9'd15)
                    : (frc_cnt_ff >= eff_frc - 9'd1);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            osc_in_q_ff <= 1'b0;
            second_q_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            osc_in_q_ff <= osc_in_pin;
            second_q_ff <= second_crystal_in_pin;
        end
    end

    // Slow RC reference, driven out on slow_rc_clk
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            slow_cnt_ff <= 10'h000;
            slow_rc_ff  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (slow_cnt_ff >= 10'(`SLOW_RC_HALF_CYC - 1))
            begin
                slow_cnt_ff <= 10'h000;
                slow_rc_ff  <= ~slow_rc_ff;
            end
            else
                slow_cnt_ff <= slow_cnt_ff + 10'h001;
        end
    end
    assign slow_rc_clk = slow_rc_ff;

    always_comb
    begin
        case (source_sel_e'(src_ff))
            SRC_FAST_RC:      src_tick = 1'b1;
            SRC_FAST_RC_PLL:  src_tick = pll_ref_tick;
            SRC_PRIMARY:      src_tick = osc_in_q_ff && !osc_in_pin;
            SRC_PRIMARY_PLL:  src_tick = pll_ref_tick;
            SRC_SECOND:       src_tick = second_q_ff
                                         && !second_crystal_in_pin;
            SRC_SLOW_RC:      src_tick = (slow_cnt_ff == 10'h000)
                                         && slow_rc_ff;
            SRC_FAST_RC_D16:  src_tick = frc_tick;
            SRC_FAST_RC_DIVN: src_tick = frc_tick;
            default:          src_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            half_ff      <= 1'b0;
            sys_osc_tick <= 1'b0;
            instr_clk_en <= 1'b0;
        end
        else if (clk_en)
        begin
            sys_osc_tick <= src_tick;
            instr_clk_en <= src_tick && half_ff;
            if (src_tick)
                half_ff <= ~half_ff;
        end
    end

    // ==========================================================
    // Output pin role and auxiliary clock
    logic crystal_on_pins;

    assign crystal_on_pins = use_primary && (pri_ff != PRI_EXTERNAL);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            osc_out_pin_o  <= 1'b0;
            osc_out_pin_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            // No drive before the configuration word is captured
            osc_out_pin_oe <= captured_ff && !crystal_on_pins
                              && !pin_fn_ff;
            osc_out_pin_o  <= half_ff;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            auxiliary_clock_source <= 1'b0;
        else if (clk_en)
            auxiliary_clock_source <= aux_sel_ff ? second_q_ff : aux_clk_in;
    end

    assign active_source = src_ff;

    // ==========================================================
    // Read data
    always_comb
    begin
        case (haddr[11:0])
            `OFS_CLOCK_DIVISOR: nxt_rdata = {16'h0000, clock_divisor_reg_ff};
            `OFS_PLL_FEEDBACK:  nxt_rdata = {23'h00_0000, pll_feedback_reg_ff};
            `OFS_FAST_RC_TUNE:  nxt_rdata = {26'h000_0000, tune_ff};
            `OFS_SOURCE_CFG:    nxt_rdata = {26'h000_0000, src_ff, pri_ff,
                                             pin_fn_ff};
            `OFS_STATUS:        nxt_rdata = {26'h000_0000, use_pll,
                                             cfg_bad, src_ff, post_bad};
            `OFS_AUX_CFG:       nxt_rdata = {31'h0000_0000, aux_sel_ff};
            default:            nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            hrdata_ff <= 32'h0000_0000;
        else if (clk_en && bus_take && !hwrite)
            hrdata_ff <= nxt_rdata;
    end

endmodule

`default_nettype wire

/* bench/clk_sel_checker.sv */
// Port checker for the clock select and PLL block
`timescale 1ns/10ps
`default_nettype none

module clk_sel_checker
    import clk_sel_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic [5:0]  source_select_cfg_word,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hsel,
    input wire logic        hready,
    input wire logic        osc_out_pin_oe,
    input wire logic        instr_clk_en,
    input wire logic        sys_osc_tick,
    input wire logic        slow_rc_clk,
    input wire logic [2:0]  active_source,
    input wire logic [31:0] fosc_ratio_num,
    input wire logic [15:0] fosc_ratio_den
);
    logic [9:0] slow_cnt_ff;
    logic       slow_prev_ff;
    logic       slow_seen_ff;
    logic [3:0] quiet_ff;
    logic       pll_src;
    logic       pri_xtal;

    assign pll_src  = active_source inside {3'h1, 3'h3};
    assign pri_xtal = source_select_cfg_word[5:4] == 2'h1
                      && source_select_cfg_word[2:1] inside {2'h1, 2'h2};

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Enabled cycles since the slow reference last changed
    always_ff @(posedge clk)
    begin
        slow_prev_ff <= slow_rc_clk;
        slow_seen_ff <= !rst && (slow_seen_ff || slow_rc_clk != slow_prev_ff);
        if (rst || slow_rc_clk != slow_prev_ff)
            slow_cnt_ff <= 10'h000;
        else if (clk_en)
            slow_cnt_ff <= slow_cnt_ff + 10'h001;
    end

    // Cycles since the last register write
    always_ff @(posedge clk)
    begin
        if (rst || (hsel && hready && htrans[1] && hwrite))
            quiet_ff <= 4'h0;
        else if (quiet_ff != 4'hF)
            quiet_ff <= quiet_ff + 4'h1;
    end

    // ==========================================================
    // Properties
    instr_half_a: assert property (
        instr_clk_en && clk_en |=> !instr_clk_en)
        else $error("instruction enable on adjacent cycles");
    instr_tick_a: assert property (
        instr_clk_en |-> sys_osc_tick || $past(sys_osc_tick))
        else $error("instruction enable without oscillator tick");
    slow_period_a: assert property (
        slow_seen_ff && slow_rc_clk != slow_prev_ff |-> slow_cnt_ff == 609)
        else $error("slow reference half period wrong");
    slow_bound_a: assert property (
        slow_seen_ff |-> slow_cnt_ff <= 10'h261)
        else $error("slow reference stopped");
    source_hold_a: assert property (
        !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
        |-> $stable(active_source))
        else $error("active source changed without reset");
    ratio_hold_a: assert property (
        quiet_ff == 4'hF |-> $stable(fosc_ratio_num) && $stable(fosc_ratio_den))
        else $error("clock ratio changed without a write");
    bypass_ratio_a: assert property (
        quiet_ff == 4'hF && !pll_src |-> fosc_ratio_num == 32'h0000_0001)
        else $error("multiplier applied to a bypass source");
    reset_ratio_a: assert property (
        $fell(rst) |-> fosc_ratio_num == 32'h0000_0001
                       && fosc_ratio_den == 16'h0001)
        else $error("clock ratio not unity after reset");
    pin_oe_a: assert property (
        osc_out_pin_oe |-> !source_select_cfg_word[0] && !pri_xtal)
        else $error("output pin driven while not allowed");
endmodule

bind clk_sel_pll clk_sel_checker chk_i (
    .clk(clk), .rst(rst), .clk_en(clk_en),
    .source_select_cfg_word(source_select_cfg_word),
    .htrans(htrans), .hwrite(hwrite), .hsel(hsel), .hready(hready),
    .osc_out_pin_oe(osc_out_pin_oe), .instr_clk_en(instr_clk_en),
    .sys_osc_tick(sys_osc_tick), .slow_rc_clk(slow_rc_clk),
    .active_source(active_source), .fosc_ratio_num(fosc_ratio_num),
    .fosc_ratio_den(fosc_ratio_den)
);

`default_nettype wire

/* bench/system_clock_select_pll_tb_top.sv */
// Self-checking bench for the clock select and PLL block
`timescale 1ns/10ps
`default_nettype none

module system_clock_select_pll_tb_top
    import clk_sel_pkg::*;
;
    typedef struct packed {
        logic [5:0]  cfg;
        logic [15:0] div;
        logic [8:0]  fbd;
        logic [2:0]  src;
        logic [31:0] num;
        logic [15:0] den;
        logic        oe;
    } row_s;

    logic        clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic [5:0]  source_select_cfg_word = 6'h07;
    logic        osc_in_pin = 1'b0, second_crystal_in_pin = 1'b0;
    logic        aux_clk_in = 1'b0, pll_ref_tick = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0, hsel = 1'b0;
    logic [2:0]  hsize = 3'h2;
    wire  logic  hready;
    logic [31:0] hrdata, fosc_ratio_num, rd;
    logic        hreadyout, osc_out_pin_oe, instr_clk_en, slow_rc_clk;
    logic [2:0]  active_source;
    logic [15:0] fosc_ratio_den;
    int          n_fail = 0, compares = 0, cnt;
    row_s        rows [0:7];
    logic [15:0] frc_den [0:7];

    always #12.5 clk = ~clk;
    assign hready = hreadyout;

    clk_sel_pll dut (
        .clk(clk), .rst(rst), .clk_en(clk_en),
        .source_select_cfg_word(source_select_cfg_word),
        .osc_in_pin(osc_in_pin), .second_crystal_in_pin(second_crystal_in_pin),
        .aux_clk_in(aux_clk_in), .pll_ref_tick(pll_ref_tick),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .osc_out_pin_o(),
        .osc_out_pin_oe(osc_out_pin_oe), .instr_clk_en(instr_clk_en),
        .sys_osc_tick(), .slow_rc_clk(slow_rc_clk),
        .auxiliary_clock_source(), .active_source(active_source),
        .fosc_ratio_num(fosc_ratio_num), .fosc_ratio_den(fosc_ratio_den)
    );

    // ==========================================================
    // Free-running clock inputs
    always @(posedge clk)
    begin
        osc_in_pin            <= ~osc_in_pin;
        second_crystal_in_pin <= ~second_crystal_in_pin;
        aux_clk_in            <= ~aux_clk_in;
        pll_ref_tick          <= ~pll_ref_tick;
    end

    // ==========================================================
    // Tasks
    task automatic tally_and_finish;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One single AHB transfer, zero or more wait states
    task automatic bus(input logic wr, input logic [31:0] addr,
                       input logic [31:0] wdata);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= addr;
        do @(posedge clk); while (!hreadyout);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wdata;
        do @(posedge clk); while (!hreadyout);
        rd = hrdata;
    endtask

    task automatic rd_chk(input string what, input logic [31:0] addr,
                          input logic [31:0] exp);
        bus(1'b0, addr, 32'h0000_0000);
        chk(what, rd, exp);
    endtask

    task automatic do_reset(input logic [5:0] cfg);
        @(posedge clk);
        rst                    <= 1'b1;
        source_select_cfg_word <= cfg;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic set_pll(input logic [15:0] div, input logic [8:0] fbd);
        bus(1'b1, 32'h0000_0000, {16'h0000, div});
        bus(1'b1, 32'h0000_0004, {23'h00_0000, fbd});
        repeat (8) @(posedge clk);
    endtask

    // ==========================================================
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        rows = '{
            '{6'h06, 16'h0040, 9'h030, 3'h0, 32'h0000_0001, 16'h0001, 1'b1},
            '{6'h1A, 16'h0000, 9'h01E, 3'h3, 32'h0000_0020, 16'h0004, 1'b0},
            '{6'h0F, 16'h00DF, 9'h000, 3'h1, 32'h0000_0002, 16'h0108, 1'b0},
            '{6'h1C, 16'h0041, 9'h1FF, 3'h3, 32'h0000_0201, 16'h000C, 1'b0},
            '{6'h36, 16'h0040, 9'h030, 3'h6, 32'h0000_0001, 16'h0010, 1'b1},
            '{6'h10, 16'h0040, 9'h030, 3'h2, 32'h0000_0001, 16'h0001, 1'b1},
            '{6'h27, 16'h0040, 9'h030, 3'h4, 32'h0000_0001, 16'h0001, 1'b0},
            '{6'h2E, 16'h0040, 9'h030, 3'h5, 32'h0000_0001, 16'h0001, 1'b1}};
        frc_den = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
                    16'h0010, 16'h0020, 16'h0040, 16'h0100};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk("divisor", 32'h0000_0000, 32'h0000_0040);
        rd_chk("feedback", 32'h0000_0004, 32'h0000_0030);
        rd_chk("tune", 32'h0000_0008, 32'h0000_0000);
        rd_chk("unmapped", 32'h0000_0020, 32'h0000_0000);
        rd_chk("cfg", 32'h0000_000C, 32'h0000_0007);
        chk("default_src", active_source, 32'h0000_0000);
        bus(1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
        rd_chk("div_mask", 32'h0000_0000, 32'h0000_07DF);
        bus(1'b1, 32'h0000_000C, 32'h0000_003F);
        rd_chk("cfg_ro", 32'h0000_000C, 32'h0000_0007);
        bus(1'b1, 32'h0000_0008, 32'h0000_003F);
        rd_chk("tune_rw", 32'h0000_0008, 32'h0000_003F);
        foreach (rows[i])
        begin
            do_reset(rows[i].cfg);
            set_pll(rows[i].div, rows[i].fbd);
            chk("source", active_source, rows[i].src);
            chk("ratio_num", fosc_ratio_num, rows[i].num);
            chk("ratio_den", fosc_ratio_den, rows[i].den);
            chk("pin_oe", osc_out_pin_oe, rows[i].oe);
        end
        // Reserved postscaler keeps the running dividers
        do_reset(6'h1A);
        set_pll(16'h0000, 9'h01E);
        set_pll(16'h0080, 9'h01E);
        chk("held_num", fosc_ratio_num, 32'h0000_0020);
        chk("held_den", fosc_ratio_den, 32'h0000_0004);
        // Every fast RC postscale code
        do_reset(6'h3E);
        for (int k = 0; k < 8; k++)
        begin
            set_pll({5'h00, k[2:0], 8'h40}, 9'h030);
            chk("frc_den", fosc_ratio_den, frc_den[k]);
        end
        // Instruction rate, freeze, slow reference
        do_reset(6'h06);
        repeat (20) @(posedge clk);
        cnt = 0;
        repeat (40) @(posedge clk) cnt += int'(instr_clk_en === 1'b1);
        chk("instr_rate", cnt, 32'h0000_0014);
        // Freeze just as the enable pulse drops
        @(posedge clk iff instr_clk_en === 1'b1);
        clk_en <= 1'b0;
        repeat (2) @(posedge clk);
        cnt = 0;
        repeat (10) @(posedge clk) cnt += int'(instr_clk_en === 1'b1);
        chk("frozen", cnt, 32'h0000_0000);
        clk_en <= 1'b1;
        @(posedge clk);
        rd = {31'h0000_0000, slow_rc_clk};
        cnt = 0;
        repeat (1220)
        begin
            @(posedge clk);
            cnt += int'(slow_rc_clk !== rd[0]);
            rd[0] = slow_rc_clk;
        end
        chk("slow_toggles", cnt, 32'h0000_0002);
        tally_and_finish();
    end
endmodule

`default_nettype wire
